// ==== src/sbt_pkg.sv ====
// Purpose: constants for the transfer format control block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   offsets are byte addresses
package sbt_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [5:0] ADDR_FORMAT = 6'h04;
	localparam logic [5:0] ADDR_MODE   = 6'h10;
	localparam logic [5:0] ADDR_DIVCNT = 6'h18;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int BPT_LSB  = 5;
	localparam int ACK_BIT  = 4;
	localparam int ONE_BIT  = 3;
	localparam int DIV_LSB  = 0;
	localparam int MODE_LSB = 2;
	localparam int SRC_LSB  = 0;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [2:0] BPT_RST  = 3'h0;
	localparam logic [2:0] DIV_RST  = 3'h0;
	localparam logic       ACK_RST  = 1'h0;
	localparam logic [1:0] MODE_RST = 2'h0;

	// ------------------------------------------------------------------
	// codes
	// ------------------------------------------------------------------
	localparam logic [1:0] SRC_ARM  = 2'h2;
	localparam logic [1:0] SRC_FIRE = 2'h1;
	localparam logic [2:0] DIV_RESV = 3'h7;
	localparam int         EXP_BASE = 5;
	localparam int         DIV_ADD  = 72;
	localparam int         SRST_CYC = 4;

	typedef enum logic [1:0] {
		SBT_PORT = 2'b00,
		SBT_SIO  = 2'b01,
		SBT_I2C  = 2'b10,
		SBT_RESV = 2'b11
	} sbt_mode_e;

endpackage : sbt_pkg

// ==== src/sbt_transfer_format_control.sv ====
// Purpose: transfer format control register with SCL divider and counts
// Assumes: single clock, synchronous active-low reset, AXI4-Lite slave
// Notes:   answers one cycle after both address and data are held

// Notes on behaviour
// - length code 000 is eight, else code
// - clocks equal length, plus one with ack
// - master emits ack pulse only when set
// - slave counts ack pulse only when set
// - divider codes 0-6 give n 5-11
// - bit 0 reads soft reset monitor
// - shared bit reads one after reset
// - writing SIO mode clears low divider bit
// - divider code starts at 000
// - mode field decodes port, SIO, I2C, reserved
module sbt_transfer_format_control
	import sbt_pkg::*;
#(
	// soft reset length in clocks, must fit the 3-bit counter
	parameter int SRST_CYCLES = SRST_CYC
)
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// transfer engine side
	input  wire logic        master_sel,
	output logic [3:0]       data_bits,
	output logic [3:0]       clocks_per_xfer,
	output logic             ack_pulse_emit,
	output logic             ack_pulse_count,
	output logic [3:0]       div_exponent,
	output logic             div_reserved,
	output logic             scl_tick,
	output logic [1:0]       interface_mode_select,
	output logic             soft_reset_pulse,
	output logic             serial_out_enable
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [2:0]  bits_per_transfer_q;
	logic        ack_q;
	logic [2:0]  div_q;
	logic [1:0]  mode_q;
	logic [1:0]  src_last_q;
	logic [2:0]  srst_cnt_q;
	logic [11:0] div_cnt_q;
	logic        tick_q;
	logic        bvalid_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  bresp_q;
	logic [1:0]  rresp_q;
	logic [3:0]  bits_q;
	logic [3:0]  clocks_q;
	logic        emit_q;
	logic        count_q;
	logic        aw_held_q;
	logic        w_held_q;
	logic [5:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	if (SRST_CYCLES < 1 || SRST_CYCLES > 7) begin : g_srst_chk
		$error("soft reset length must be 1 to 7 clocks");
	end

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	wire         aw_free   = ~aw_held_q & ~bvalid_q;
	wire         w_free    = ~w_held_q & ~bvalid_q;
	wire         aw_take   = s_axi_awvalid & aw_free;
	wire         w_take    = s_axi_wvalid & w_free;
	// a write goes ahead once both halves are in hand, in either order
	wire         wr_go     = (aw_held_q | aw_take) & (w_held_q | w_take)
		& ~bvalid_q;
	wire [5:0]   wr_addr   = aw_held_q ? awaddr_q : s_axi_awaddr;
	wire [31:0]  wr_data   = w_held_q ? wdata_q : s_axi_wdata;
	wire [3:0]   wr_strb   = w_held_q ? wstrb_q : s_axi_wstrb;
	wire         rd_go     = s_axi_arvalid & ~rvalid_q;
	wire         wr_fmt    = wr_go & (wr_addr == ADDR_FORMAT);
	wire         wr_mode   = wr_go & (wr_addr == ADDR_MODE);
	wire         wr_hit    = wr_fmt | wr_mode;
	wire         rd_fmt    = s_axi_araddr == ADDR_FORMAT;
	wire         rd_mode   = s_axi_araddr == ADDR_MODE;
	wire         rd_dcnt   = s_axi_araddr == ADDR_DIVCNT;
	wire         rd_hit    = rd_fmt | rd_mode | rd_dcnt;
	wire         lane0     = wr_strb[0];
	wire [1:0]   src_wr    = wr_data[SRC_LSB +: 2];
	wire [1:0]   mode_wr   = wr_data[MODE_LSB +: 2];
	// arm-then-fire; a second arm keeps the sequence armed
	wire         src_fire  = wr_mode & lane0 & (src_wr == SRC_FIRE)
		& (src_last_q == SRC_ARM);
	wire         srst_busy = srst_cnt_q != 3'h0;
	wire         mode_sio  = mode_q == SBT_SIO;
	// monitor shares bit 0 with the divider's write-only low bit
	wire         monitor   = ~srst_busy;
	wire [31:0]  fmt_rd    = {24'h0, bits_per_transfer_q, ack_q, 1'b1,
		div_q[2:1], monitor};
	wire [31:0]  mode_rd   = {28'h0, mode_q, 2'h0};
	wire [31:0]  dcnt_rd   = {20'h0, div_cnt_q};
	wire [31:0]  rd_mux    = rd_fmt ? fmt_rd : rd_mode ? mode_rd : dcnt_rd;

	assign s_axi_awready = aw_free;
	assign s_axi_wready  = w_free;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// ------------------------------------------------------------------
	// derived transfer format
	// ------------------------------------------------------------------
	wire [3:0]   len_d     = (bits_per_transfer_q == 3'h0) ? 4'h8
		: {1'b0, bits_per_transfer_q};
	wire [3:0]   clk_d     = len_d + {3'h0, ack_q};
	wire [3:0]   exp_d     = 4'(EXP_BASE) + {1'b0, div_q};
	// period is 2^n + 72 system clocks
	wire [11:0]  period    = 12'(12'h1 << exp_d) + 12'(DIV_ADD);
	wire         div_wrap  = div_cnt_q >= period - 12'h1;
	wire         run_div   = (mode_q == SBT_I2C) & (div_q != DIV_RESV);

	assign data_bits             = bits_q;
	assign clocks_per_xfer       = clocks_q;
	assign ack_pulse_emit        = emit_q;
	assign ack_pulse_count       = count_q;
	assign div_exponent          = exp_d;
	assign div_reserved          = div_q == DIV_RESV;
	assign scl_tick              = tick_q;
	assign interface_mode_select = mode_q;
	assign soft_reset_pulse      = srst_busy;
	assign serial_out_enable     = mode_q != SBT_PORT;

	// ------------------------------------------------------------------
	// format register
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bits_per_transfer_q <= BPT_RST;
			ack_q               <= ACK_RST;
			div_q               <= DIV_RST;
		end else if (wr_fmt & lane0) begin
			bits_per_transfer_q <= wr_data[BPT_LSB +: 3];
			ack_q               <= wr_data[ACK_BIT];
			div_q               <= wr_data[DIV_LSB +: 3];
		end else if (wr_mode & lane0 & (mode_wr == SBT_SIO)) begin
			div_q[0]            <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// mode and soft reset
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q     <= MODE_RST;
			src_last_q <= 2'h0;
			srst_cnt_q <= 3'h0;
		end else begin
			if (wr_mode & lane0) begin
				mode_q     <= mode_wr;
				src_last_q <= src_wr;
			end
			if (src_fire)
				srst_cnt_q <= 3'(SRST_CYCLES);
			else if (srst_busy)
				srst_cnt_q <= srst_cnt_q - 3'h1;
		end
	end

	// ------------------------------------------------------------------
	// ack handling and lengths
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bits_q   <= 4'h8;
			clocks_q <= 4'h8;
			emit_q   <= 1'b0;
			count_q  <= 1'b0;
		end else begin
			bits_q   <= len_d;
			clocks_q <= clk_d;
			emit_q   <= master_sel & ack_q;
			count_q  <= ~master_sel & ack_q;
		end
	end

	// ------------------------------------------------------------------
	// SCL divider; restarts whenever soft reset is running
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_q <= 12'h0;
			tick_q    <= 1'b0;
		end else if (!run_div | srst_busy) begin
			div_cnt_q <= 12'h0;
			tick_q    <= 1'b0;
		end else begin
			div_cnt_q <= div_wrap ? 12'h0 : div_cnt_q + 12'h1;
			tick_q    <= div_wrap;
		end
	end

	// ------------------------------------------------------------------
	// write channel capture
	// ------------------------------------------------------------------
	// a lone half is parked here so the master may offer them apart
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 6'h0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
		end else if (wr_go) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
		end
	end

	// ------------------------------------------------------------------
	// bus responses
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= 2'h0;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? 2'h0 : 2'h3;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= 2'h0;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_hit ? rd_mux : 32'h0;
			rresp_q  <= rd_hit ? 2'h0 : 2'h3;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule : sbt_transfer_format_control

// ==== verif/sbt_fmt_chk_properties.sv ====
// Purpose: assertions on the engine side outputs
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the design top by the bench
module sbt_fmt_chk (
	// watched ports
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       master_sel,
	input wire logic [3:0] data_bits,
	input wire logic [3:0] clocks_per_xfer,
	input wire logic       ack_pulse_emit,
	input wire logic       ack_pulse_count,
	input wire logic [3:0] div_exponent,
	input wire logic       div_reserved,
	input wire logic       scl_tick,
	input wire logic [1:0] interface_mode_select,
	input wire logic       serial_out_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------
	// checks
	// ----------------
	a_len_range: assert property (data_bits inside {[1:8]})
		else $error("data length out of range");
	// skipped while the length moves, though both counts are registered in the same cycle
	a_clk_count: assert property ($stable(data_bits) |->
		clocks_per_xfer - data_bits inside {0, 1})
		else $error("clock count not length or length plus one");
	a_ack_master: assert property (ack_pulse_emit |-> $past(master_sel))
		else $error("ack pulse emitted in slave mode");
	a_ack_slave: assert property (ack_pulse_count |-> !$past(master_sel))
		else $error("ack pulse counted in master mode");
	a_div_resv: assert property (
		div_reserved == (div_exponent == 4'hC))
		else $error("reserved divider flag wrong");
	a_out_en: assert property (
		serial_out_enable == (interface_mode_select != 2'h0))
		else $error("serial output enable wrong for mode");
	a_scl_mode: assert property (
		scl_tick |-> $past(interface_mode_select) == 2'h2)
		else $error("scl tick outside bus mode");
	a_scl_gap: assert property (scl_tick |=> !scl_tick [*8])
		else $error("scl ticks too close");
endmodule : sbt_fmt_chk

// ==== verif/sbt_engine_model.sv ====
// Purpose: transfer engine stand-in on the far side
// Assumes: same clock as the block
// Notes:   measures the scl tick period in clocks
module sbt_engine_model (
	// engine signals
	input wire logic aclk,
	input wire logic want_master,
	input wire logic scl_tick,
	output logic     master_sel = 1'h0,
	output int       gap = 0
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	always @(posedge aclk) begin
		master_sel <= want_master;
		cnt <= scl_tick ? 0 : cnt + 1;
		if (scl_tick)
			gap <= cnt + 1;
	end
endmodule : sbt_engine_model

// ==== verif/sbt_transfer_format_control_tb.sv ====
// Purpose: bench for the transfer format control block
// Assumes: 25 MHz aclk, reset held six cycles
// Notes:   bready and rready stay high, both are always accepted
bind sbt_transfer_format_control sbt_fmt_chk sbt_fmt_chk_inst (.*);
module sbt_transfer_format_control_tb import sbt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0, aresetn = 1'h0, want_master = 1'h0, master_sel;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, s_axi_awready;
	logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 4'hF, data_bits, clocks_per_xfer, div_exponent;
	logic [1:0] s_axi_bresp, s_axi_rresp, interface_mode_select, resp;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic ack_pulse_emit, ack_pulse_count, div_reserved, scl_tick;
	logic soft_reset_pulse, serial_out_enable;
	int n_fail = 0, checks_done = 0, gap;
	always #20 aclk = ~aclk;
	sbt_transfer_format_control sbt_transfer_format_control_inst (.*);
	sbt_engine_model sbt_engine_model_inst (.*);
	// ----------------
	// tasks
	// ----------------
	task automatic finish_test;
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] s, e, input string n);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// bounded wait; a hang ends the run as a failure
	task automatic wt(ref logic s);
		for (int i = 0; i < 3000; i++) begin
			@(posedge aclk);
			if (s === 1'h1)
				return;
		end
		n_fail++;
		finish_test();
	endtask : wt
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		wt(s_axi_awready);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		wt(s_axi_bvalid);
		resp = s_axi_bresp;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [5:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		wt(s_axi_arready);
		s_axi_arvalid <= 1'h0;
		wt(s_axi_rvalid);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
	endtask : rd
	task automatic t_rst;
		rd(ADDR_FORMAT);
		chk(rdat, 32'h9, "fmt_rst");
		chk(data_bits, 4'h8, "len_rst");
		rd(6'h0C);
		chk(resp, 2'h3, "rresp_unmapped");
		wr(6'h08, 32'h0);
		chk(resp, 2'h3, "bresp_unmapped");
	endtask : t_rst
	task automatic t_len;
		logic [3:0] c, n;
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			n = (c[3:1] == 3'h0) ? 4'h8 : {1'h0, c[3:1]};
			want_master <= c[1];
			wr(ADDR_FORMAT, {24'hFFFFFF, c, 4'h0});
			chk(data_bits, n, "len");
			chk(clocks_per_xfer, n + c[0], "clocks");
			chk(ack_pulse_emit, c[0] & c[1], "emit");
			chk(ack_pulse_count, c[0] & ~c[1], "count");
			rd(ADDR_FORMAT);
			chk(rdat, {24'h0, c, 4'h9}, "fmt");
		end
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_FORMAT, i);
			chk(div_exponent, EXP_BASE + i, "exp");
			chk(div_reserved, i == 7, "resv");
		end
	endtask : t_len
	task automatic t_mode;
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_FORMAT, 32'h1);
			wr(ADDR_MODE, m << 2);
			chk(interface_mode_select, m, "mode");
			chk(serial_out_enable, m != 0, "oe");
			chk(div_exponent, (m == 1) ? 5 : 6, "sio");
			rd(ADDR_MODE);
			chk(rdat, m << 2, "mode_rd");
		end
	endtask : t_mode
	task automatic t_soft;
		wr(ADDR_MODE, {SBT_I2C, SRC_ARM});
		wr(ADDR_MODE, {SBT_I2C, SRC_FIRE});
		chk(soft_reset_pulse, 1'h1, "srst_on");
		rd(ADDR_FORMAT);
		chk(rdat[0], 1'h0, "busy");
		repeat (8) @(posedge aclk);
		chk(soft_reset_pulse, 1'h0, "srst_off");
		wr(ADDR_MODE, {SBT_I2C, SRC_FIRE});
		rd(ADDR_FORMAT);
		chk(rdat[0], 1'h1, "idle");
		for (int d = 0; d < 2; d++) begin
			wr(ADDR_FORMAT, d);
			repeat (3) wt(scl_tick);
			chk(gap, 2 ** (EXP_BASE + d) + DIV_ADD, "scl");
		end
	endtask : t_soft
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_rst();
		t_len();
		t_mode();
		t_soft();
		finish_test();
	end
endmodule : sbt_transfer_format_control_tb
